// file: shared/psw_pkg.sv
// constants and types for the serial port power-save wake block
`default_nettype none
package psw_pkg;
  // power-save configurations
  typedef enum logic [1:0] {
    PS_OFF    = 2'h0,
    PS_CYCLIC = 2'h1,
    PS_RTS    = 2'h2,
    PS_RSVD   = 2'h3
  } ps_cfg_t;

  // power state
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'h0,
    ST_IDLE   = 2'h1,
    ST_WAKING = 2'h2
  } pwr_state_t;

  localparam int unsigned CLK_HZ       = 10000000;
  localparam int unsigned WAKE_TIME_MS = 20;
  // 20 ms at 10 MHz = 200000 cycles, a top-level parameter default
  localparam int unsigned WAKE_CYCLES  = (WAKE_TIME_MS * (CLK_HZ / 1000));
  localparam int unsigned WAKE_CNT_W   = 18;
  localparam logic [7:0]  DATA_RESET   = 8'h00;
  localparam logic [1:0]  CFG_RESET    = 2'h0;
  localparam int unsigned BUF_DEPTH    = 2;
endpackage : psw_pkg
`default_nettype wire

// file: rtl/uart_power_save_wake.sv
// serial port power-save, flow-control gating and idle wake-up
`default_nettype none

// Behaviour
// [RL1] flow control on, request off: hold outgoing
// [RL2] flow control off: transmit regardless, may lose
// [RL3] host holds data until active mode
// [RL4] mode 1 no flow: data edge wakes, 20ms
// [RL5] waking character dropped; data valid after wake
// [RL6] mode 2 refuses flow control
// [RL7] mode 2 request on forces active
// [RL8] mode 2 request turning on wakes, 20ms
// [RL9] mode 2 request off: data edge wakes
// [RL10] mode 0 never idle, port enabled
// [RL11] mode 0 clear-to-send held on
// [RL12] reset selects mode 0
// [RL13] mode 0 receives all host data
module uart_power_save_wake #(
  parameter int unsigned WAKE_CYCLES = psw_pkg::WAKE_CYCLES
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // configuration commands (one-cycle strobes)
  input  wire logic       power_save_config_cmd,
  input  wire logic [1:0] power_save_cfg,
  input  wire logic       flow_control_on_cmd,
  input  wire logic       flow_control_off_cmd,
  // idle request from the rest of the module
  input  wire logic       idle_req,
  // serial line levels (rts_n low = ON)
  input  wire logic       rts_n,
  input  wire logic       txd_in,
  output logic            cts_n,
  // received characters from the deserialiser
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  output logic            rx_out_valid,
  output logic [7:0]      rx_out_data,
  // outgoing characters toward the serialiser
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  output logic            tx_out_valid,
  input  wire logic       tx_out_ready,
  output logic [7:0]      tx_out_data,
  // status
  output logic            port_enabled,
  output logic            is_idle,
  output logic            cfg_refused
);

  ////////////////////////////////////////////////////////////////////////////
  // configuration
  logic [1:0]           cfg_r;
  logic                 flow_r;
  logic                 refused_r;
  logic                 rts_prev_r;
  logic                 txd_prev_r;
  psw_pkg::pwr_state_t  state_r;
  psw_pkg::pwr_state_t  state_nxt;
  logic [psw_pkg::WAKE_CNT_W-1:0] cnt_r;

  wire rts_on      = ~rts_n;
  wire mode0       = (cfg_r == psw_pkg::PS_OFF);
  wire mode2       = (cfg_r == psw_pkg::PS_RTS);
  wire cfg_legal   = (power_save_cfg != psw_pkg::PS_RSVD);
  // mode 2 with flow control on is not applicable: refuse either order
  // a flow-on strobe in the same cycle counts as flow control already on
  wire flow_on_now = flow_r || flow_control_on_cmd;
  wire cfg_bad     = power_save_config_cmd &&
                     (((power_save_cfg == psw_pkg::PS_RTS) && flow_on_now) || !cfg_legal); // see [RL6]
  wire flow_bad    = flow_control_on_cmd && mode2;                                  // see [RL6]
  wire cfg_take    = power_save_config_cmd && !cfg_bad;
  wire flow_take   = flow_control_on_cmd && !flow_bad;

  // settings change only on accepted commands
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_r     <= psw_pkg::CFG_RESET;                 // see [RL12]
      flow_r    <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      if (cfg_take)
        cfg_r <= power_save_cfg;
      if (flow_take)
        flow_r <= 1'b1;
      else if (flow_control_off_cmd)
        flow_r <= 1'b0;
      refused_r <= cfg_bad | flow_bad;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake sources
  wire txd_rise   = txd_in & ~txd_prev_r;
  wire rts_fall   = rts_on & ~rts_prev_r;              // OFF-to-ON, high-to-low
  // flow-controlled mode 1 does not wake on data; the host holds it instead
  wire wake_txd   = txd_rise && ((cfg_r == psw_pkg::PS_CYCLIC) && !flow_r ||  // see [RL4]
                                 mode2 && !rts_on);                         // see [RL9]
  wire wake_rts   = mode2 && rts_fall;                                     // see [RL8]
  wire wake_any   = wake_txd | wake_rts;
  // idle allowed only outside mode 0 and outside mode 2 with request on
  wire idle_ok    = idle_req && !mode0 && !(mode2 && rts_on);             // see [RL7] see [RL10]
  localparam int unsigned WAKE_CNT_W = psw_pkg::WAKE_CNT_W;
  wire cnt_done   = (cnt_r == WAKE_CNT_W'(WAKE_CYCLES - 1));

  // power state machine
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      psw_pkg::ST_ACTIVE: begin
        if (idle_ok)
          state_nxt = psw_pkg::ST_IDLE;
      end
      psw_pkg::ST_IDLE: begin
        if (mode0 || (mode2 && rts_on && !rts_fall))
          state_nxt = psw_pkg::ST_ACTIVE;           // forced, see [RL7] see [RL10]
        else if (wake_any)
          state_nxt = psw_pkg::ST_WAKING;           // see [RL4] see [RL8] see [RL9]
      end
      psw_pkg::ST_WAKING: begin
        if (cnt_done || mode0)
          state_nxt = psw_pkg::ST_ACTIVE;
      end
      default: state_nxt = psw_pkg::ST_ACTIVE;
    endcase
  end

  // state, edge history and the wake timer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r    <= psw_pkg::ST_ACTIVE;
      cnt_r      <= '0;
      rts_prev_r <= 1'b0;
      txd_prev_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      rts_prev_r <= rts_on;
      txd_prev_r <= txd_in;
      if (state_r == psw_pkg::ST_WAKING && !cnt_done)
        cnt_r <= cnt_r + 1'b1;                      // 20 ms wake time, see [RL4]
      else
        cnt_r <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port enable and clear-to-send
  wire active     = (state_r == psw_pkg::ST_ACTIVE);

  // mode 2, request off: a data edge re-opens the port until idle returns;
  // without it the port would open only to send and the host's next
  // characters after the wake time would be dropped
  logic reen_r;
  wire  reen_set  = wake_txd && mode2;                          // see [RL9]
  wire  reen_clr  = !mode2 || rts_on || (state_nxt == psw_pkg::ST_IDLE);
  always_ff @(posedge clk_sys) begin
    if (rst)
      reen_r <= 1'b0;
    else if (reen_set)
      reen_r <= 1'b1;                                           // set wins over clear
    else if (reen_clr)
      reen_r <= 1'b0;
  end

  // mode 2 with request off keeps the port off except to send or after a data edge
  wire port_en    = mode0 || (active && !(mode2 && !rts_on)) ||
                    (mode2 && active && (tx_out_valid || reen_r)); // see [RL10] see [RL9]
  assign port_enabled = port_en;
  assign is_idle      = (state_r != psw_pkg::ST_ACTIVE);
  assign cfg_refused  = refused_r;
  // low = ON; flow control shows enable, otherwise always ON
  assign cts_n = flow_r ? ~(mode0 | active) : 1'b0;             // see [RL11]

  ////////////////////////////////////////////////////////////////////////////
  // receive path: nothing recognised until fully awake, so the waking
  // character and anything inside the wake time are dropped
  logic       rxv_r;
  logic [7:0] rxd_r;
  wire rx_accept = rx_valid && (mode0 || active) && port_en;    // see [RL5] see [RL13] see [RL3]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxv_r <= 1'b0;
      rxd_r <= psw_pkg::DATA_RESET;
    end else begin
      rxv_r <= rx_accept;
      if (rx_accept)
        rxd_r <= rx_data;
    end
  end
  assign rx_out_valid = rxv_r;
  assign rx_out_data  = rxd_r;

  ////////////////////////////////////////////////////////////////////////////
  // transmit path: two-entry buffer; with flow control the host's
  // request-to-send stalls the drain, without it characters go out anyway
  logic [7:0] buf_r [psw_pkg::BUF_DEPTH];
  logic       wp_r;
  logic       rp_r;
  logic [1:0] fill_r;
  wire buf_empty = (fill_r == 2'h0);
  wire buf_full  = (fill_r == 2'h2);
  wire drain_ok  = flow_r ? rts_on : 1'b1;                      // see [RL1] see [RL2]
  wire push      = tx_valid && !buf_full;
  wire pop       = tx_out_valid && tx_out_ready;
  assign tx_ready     = !buf_full;
  assign tx_out_valid = !buf_empty && drain_ok;
  assign tx_out_data  = buf_r[rp_r];

  // pointers and fill count
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wp_r   <= 1'b0;
      rp_r   <= 1'b0;
      fill_r <= 2'h0;
      buf_r[0] <= psw_pkg::DATA_RESET;
      buf_r[1] <= psw_pkg::DATA_RESET;
    end else begin
      if (push) begin
        buf_r[wp_r] <= tx_data;
        wp_r        <= ~wp_r;
      end
      if (pop)
        rp_r <= ~rp_r;
      fill_r <= fill_r + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : uart_power_save_wake
`default_nettype wire

// file: bench/psw_properties.sv
// port assertions for the power-save wake block
`default_nettype none
module psw_properties (
  // watched ports, grouped to keep the checker short
  input wire logic       clk_sys, rst, idle_req, is_idle, cts_n, cfg_refused, port_enabled,
  input wire logic       power_save_config_cmd, flow_control_on_cmd, rx_valid, rx_out_valid,
  input wire logic       tx_valid, tx_ready, tx_out_valid, tx_out_ready,
  input wire logic [7:0] rx_data, rx_out_data, tx_out_data
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // reset state is checked with the disable switched off
  a_reset_state: assert property (disable iff (1'b0) rst |=> !is_idle && tx_ready && !cts_n)
    else $error("reset state wrong");
  a_rx_pass_word: assert property (rx_valid && !is_idle && port_enabled |=> rx_out_valid &&
    rx_out_data == $past(rx_data)) else $error("accepted word not passed");
  a_rx_drop_idle: assert property (rx_valid && is_idle |=> !rx_out_valid)
    else $error("word taken while idle");
  a_idle_needs_req: assert property ($rose(is_idle) |-> $past(idle_req))
    else $error("idle without request");
  a_cts_off_idle: assert property (cts_n |-> is_idle) else $error("cts off while active");
  a_refuse_cause: assert property (cfg_refused |-> $past(power_save_config_cmd) ||
    $past(flow_control_on_cmd)) else $error("refusal without command");
  a_full_no_loss: assert property (!tx_ready && !tx_out_ready |=> !tx_ready)
    else $error("full buffer lost a word");
  a_stall_data_hold: assert property (tx_out_valid && !tx_out_ready |=> $stable(tx_out_data))
    else $error("stalled word changed");
  a_full_by_push: assert property ($fell(tx_ready) |-> $past(tx_valid))
    else $error("full without push");
  // main scenarios reached
  c_wake: cover property ($fell(is_idle));
  c_refused: cover property (cfg_refused);
  c_full: cover property (!tx_ready);
endmodule : psw_properties
bind uart_power_save_wake psw_properties u_props (.clk_sys, .rst, .idle_req, .is_idle, .cts_n, .cfg_refused,
  .port_enabled, .power_save_config_cmd, .flow_control_on_cmd, .rx_valid, .rx_out_valid, .tx_valid, .tx_ready,
  .tx_out_valid, .tx_out_ready, .rx_data, .rx_out_data, .tx_out_data);
`default_nettype wire

// file: bench/host_dte.sv
// host terminal model taking outgoing words
`default_nettype none
module host_dte (
  // clock and host request line
  input  wire logic       clk_sys,
  input  wire logic       rts_n,
  // words from the device
  input  wire logic       tx_out_valid,
  input  wire logic [7:0] tx_out_data,
  output logic            tx_out_ready,
  output logic [7:0]      got
);
  timeunit 1ns;
  timeprecision 1ns;
  // ready only while request is on, so the device must hold the rest
  assign tx_out_ready = !rts_n;
  // last word taken off the line
  always_ff @(posedge clk_sys) begin
    if (tx_out_valid && tx_out_ready) got <= tx_out_data;
  end
endmodule : host_dte
`default_nettype wire

// file: bench/uart_power_save_wake_tb.sv
// self-checking bench for the power-save wake block
`default_nettype none
module uart_power_save_wake_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst = 1, power_save_config_cmd = 0, flow_control_on_cmd = 0, flow_control_off_cmd = 0;
  logic idle_req = 0, rts_n = 1, txd_in = 0, rx_valid = 0, tx_valid = 0, cts_n, rx_out_valid, tx_ready;
  logic tx_out_valid, tx_out_ready, port_enabled, is_idle, cfg_refused;
  logic [1:0] power_save_cfg = 2'h0;
  logic [7:0] rx_data = 8'h00, tx_data = 8'h00, rx_out_data, tx_out_data, got;
  int num_errors = 0, check_count = 0;
  always #50 clk_sys = ~clk_sys;
  // short wake count keeps the run brief; it stands for the 20 ms wake time
  localparam int WAKE_T = 20;
  uart_power_save_wake #(.WAKE_CYCLES(WAKE_T)) DUT (.clk_sys, .rst, .power_save_config_cmd, .power_save_cfg,
    .flow_control_on_cmd, .flow_control_off_cmd, .idle_req, .rts_n, .txd_in, .cts_n, .rx_valid, .rx_data,
    .rx_out_valid, .rx_out_data, .tx_valid, .tx_ready, .tx_data, .tx_out_valid, .tx_out_ready, .tx_out_data,
    .port_enabled, .is_idle, .cfg_refused);
  host_dte HOST (.clk_sys, .rts_n, .tx_out_valid, .tx_out_data, .tx_out_ready, .got);
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  // one-cycle command strobes; the idle cycle first keeps two strobes apart
  task automatic cmd(input logic p, input logic [1:0] c, input logic on, input logic off);
    cyc(1);
    {power_save_config_cmd, power_save_cfg, flow_control_on_cmd, flow_control_off_cmd} = {p, c, on, off};
    cyc(1);
    {power_save_config_cmd, flow_control_on_cmd, flow_control_off_cmd} = 3'h0;
  endtask : cmd
  // one character from the deserialiser, valid for one edge
  task automatic rx_send(input logic [7:0] d);
    rx_valid = 1;
    rx_data = d;
    cyc(1);
    rx_valid = 0;
  endtask : rx_send
  // bounded wait for active mode; the count must equal the wake time
  task automatic wait_active(input string what);
    int n;
    n = 0;
    while (is_idle !== 1'b0 && n < 100) begin
      cyc(1);
      n++;
    end
    if (n >= 100) begin
      num_errors++;
      $display("MISMATCH %s expected active seen idle", what);
      test_done();
    end else begin
      chk(what, 8'(WAKE_T), 8'(n));
    end
  endtask : wait_active
  task automatic t_reset();
    rst = 1;
    cyc(5);
    rst = 0;
    chk("cts_n", 0, cts_n);
    chk("is_idle", 0, is_idle);
    chk("tx_ready", 1, tx_ready);
  endtask : t_reset
  task automatic t_mode0_rx();
    idle_req = 1;
    rts_n = 0;
    rx_send(8'h5a);
    chk("rx_out", 8'h5a, rx_out_data);
    chk("rx_out_valid", 1, rx_out_valid);
    cyc(2);
    chk("mode0 idle", 0, is_idle);
    chk("port_enabled", 1, port_enabled);
    idle_req = 0;
  endtask : t_mode0_rx
  // stalled host: two words fill the buffer, then drain in order
  task automatic t_flow_hold();
    cmd(0, 0, 1, 0);
    rts_n = 1;
    tx_valid = 1;
    tx_data = 8'ha1;
    cyc(1);
    tx_data = 8'hb2;
    cyc(1);
    tx_valid = 0;
    chk("full", 0, tx_ready);
    chk("held", 0, tx_out_valid);
    rts_n = 0;
    cyc(1);
    chk("first", 8'ha1, got);
    cyc(1);
    chk("second", 8'hb2, got);
    chk("empty", 0, tx_out_valid);
  endtask : t_flow_hold
  task automatic t_flow_off();
    cmd(0, 0, 0, 1);
    rts_n = 1;
    tx_valid = 1;
    tx_data = 8'hc3;
    cyc(1);
    tx_valid = 0;
    chk("sent anyway", 1, tx_out_valid);
    chk("cts flow off", 0, cts_n);
    rts_n = 0;
    cyc(1);
    chk("flow off got", 8'hc3, got);
  endtask : t_flow_off
  task automatic t_refuse();
    cmd(0, 0, 1, 0);
    cmd(1, 2, 0, 0);
    chk("mode2 with flow", 1, cfg_refused);
    cmd(1, 3, 0, 0);
    chk("cfg 3", 1, cfg_refused);
    cmd(0, 0, 0, 1);
    cmd(1, 2, 0, 0);
    chk("mode2 taken", 0, cfg_refused);
    cmd(0, 0, 1, 0);
    chk("flow in mode2", 1, cfg_refused);
  endtask : t_refuse
  // a data edge wakes; the waking character is dropped, the next one taken
  task automatic wake_by_txd();
    idle_req = 0;
    txd_in = 1;
    rx_send(8'h77);
    chk("wake char", 0, rx_out_valid);
    chk("waking", 1, is_idle);
    wait_active("txd wake time");
    txd_in = 0;
    rx_send(8'h88);
    chk("after wake", 8'h88, rx_out_data);
    chk("after wake valid", 1, rx_out_valid);
  endtask : wake_by_txd
  task automatic t_mode2();
    rts_n = 0;
    idle_req = 1;
    cyc(3);
    chk("rts on active", 0, is_idle);
    chk("rts on port", 1, port_enabled);
    rts_n = 1;
    cyc(2);
    chk("rts off idle", 1, is_idle);
    rts_n = 0;
    cyc(1);
    chk("rts waking", 1, is_idle);
    wait_active("rts wake time");
    rts_n = 1;
    cyc(2);
    chk("idle again", 1, is_idle);
    wake_by_txd();
  endtask : t_mode2
  task automatic t_mode1();
    idle_req = 1;
    cmd(1, 1, 0, 0);
    cyc(2);
    chk("mode1 idle", 1, is_idle);
    wake_by_txd();
  endtask : t_mode1
  // flow-controlled mode 1: no data wake, the host holds its character
  task automatic t_mode1_flow();
    idle_req = 1;
    cmd(0, 1, 1, 0);
    cyc(2);
    chk("flow idle", 1, is_idle);
    chk("flow cts off", 1, cts_n);
    txd_in = 1;
    cyc(3);
    chk("no data wake", 1, is_idle);
    cmd(1, 0, 0, 0);
    cyc(1);
    chk("forced active", 0, is_idle);
    chk("cts on mode0", 0, cts_n);
    txd_in = 0;
    rx_send(8'h99);
    chk("held char", 8'h99, rx_out_data);
    chk("held char valid", 1, rx_out_valid);
  endtask : t_mode1_flow
  // main sequence, ending with a mid-run reset
  initial begin
    t_reset();
    t_mode0_rx();
    t_flow_hold();
    t_flow_off();
    t_refuse();
    t_mode2();
    t_mode1();
    t_mode1_flow();
    t_reset();
    idle_req = 1;
    cyc(3);
    chk("mode0 again", 0, is_idle);
    test_done();
  end
endmodule : uart_power_save_wake_tb
`default_nettype wire
